/* File: hw/ttc_pkg.sv */
/*
  Shared constants for the trend trigger capture recorder: register offsets, field
  positions, reset values, trigger condition codes, state set and timing counts.
  Assumes a 100 MHz controller clock and a 32-bit register port.
*/
package ttc_pkg;

  localparam int NUM_CH = 8;
  localparam int DEPTH = 100;
  localparam int PTR_W = 7;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TRACE_W = 16;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam logic [14:0] RATE_MAX_MS = 15'd20000;
  localparam logic [6:0] POST_MAX_PCT = 7'd100;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_COND = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TVAL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RATE = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_POST = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_RD_SEL = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_RD_DATA = 8'h24;

  // field positions
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_TOGGLE_BIT = 1;
  localparam int CTRL_REARM_BIT = 2;
  localparam int CTRL_EN_LSB = 8;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_STOP_BIT = 1;
  localparam int STAT_POST_BIT = 2;
  localparam int STAT_CLEAR_BIT = 3;
  localparam int STAT_PTR_LSB = 8;
  localparam int SEL_CH_LSB = 8;
  localparam int IRQ_TRIG_BIT = 0;
  localparam int IRQ_DONE_BIT = 1;

  // reset values
  localparam logic RST_MODE = 1'b0;
  localparam logic [NUM_CH-1:0] RST_EN = 8'hff;
  localparam logic [TRACE_W-1:0] RST_TVAL = 16'h0018;
  localparam logic [14:0] RST_RATE = 15'h0000;
  localparam logic [6:0] RST_POST = 7'h14;

  // trigger condition codes
  localparam logic [2:0] COND_EQ = 3'h0;
  localparam logic [2:0] COND_NE = 3'h1;
  localparam logic [2:0] COND_GT = 3'h2;
  localparam logic [2:0] COND_LT = 3'h3;
  localparam logic [2:0] COND_OR = 3'h4;
  localparam logic [2:0] COND_NOR = 3'h5;
  localparam logic [2:0] COND_AND = 3'h6;
  localparam logic [2:0] COND_NAND = 3'h7;
  localparam logic [2:0] RST_COND = COND_OR;

  typedef enum logic [1:0] {
    TTC_CLEAR,
    TTC_ARMED,
    TTC_POST,
    TTC_STOP
  } ttc_state_t;

endpackage : ttc_pkg

/* File: hw/ttc_recorder.sv */
/*
  Trend trigger capture recorder: eight trace inputs sampled at a programmable
  millisecond interval into a 100-row circular buffer, with pre/post trigger split,
  eight trigger conditions on trace 0, single-shot or continuous re-arm, register
  port, sticky interrupt status with mask.
  Assumes trace inputs synchronous to i_mclk and a bus master that never overlaps
  strobes; read data is valid only in the cycle after the read strobe.
*/
// Strobed register access and the register offsets are this design's own decisions.
// Functional notes
// - up to eight trace channels, each individually enabled
// - buffer holds exactly one hundred samples per channel
// - only trace 0 feeds the trigger comparison; others are just recorded
// - sample interval programmable 0 to 20000 ms
// - interval zero means one sample every millisecond
// - post-trigger percentage 0..100; remainder holds pre-trigger samples
// - each toggle command flips between single-shot and continuous
// - single-shot triggers once, completes, stops until re-armed
// - re-arm clears the buffer before a new capture starts
// - continuous re-arms itself until a data read-out stops it
// - eight conditions: eq, ne, gt, lt, or, nor, and, nand
// - programmable trigger value is the comparison operand
// - trigger only when armed and the condition holds
// - OR with 18h, 8h, 10h selects alarm/fault, fault, alarm
// - status Running while armed, Stopped otherwise; re-arm restores Running
module ttc_recorder
  import ttc_pkg::*;
#(
  parameter int TW = ttc_pkg::TRACE_W,
  parameter int CYC_MS = ttc_pkg::CYC_PER_MS
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [ttc_pkg::NUM_CH*TW-1:0] i_trace,
  input wire logic [ttc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [ttc_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [ttc_pkg::DATA_W-1:0] o_rdata,
  output logic o_running,
  output logic o_irq
);
  import ttc_pkg::*;

  localparam int MSW = $clog2(CYC_MS);
  localparam logic [MSW-1:0] MS_LAST = MSW'(CYC_MS - 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

  typedef struct packed {
    ttc_state_t st;
    logic mode;
    logic [NUM_CH-1:0] en;
    logic [2:0] cond;
    logic [TW-1:0] tval;
    logic [14:0] rate;
    logic [6:0] post;
    logic [1:0] irq_st;
    logic [1:0] irq_mask;
    logic [PTR_W-1:0] sel_idx;
    logic [2:0] sel_ch;
    logic [MSW-1:0] ms_cnt;
    logic [14:0] iv_cnt;
    logic [PTR_W-1:0] wr_ptr;
    logic [6:0] post_left;
    logic stop_req;
    logic [DATA_W-1:0] rdata;
  } ttc_regs_t;

  ttc_regs_t q;
  ttc_regs_t d;
  logic [NUM_CH*TW-1:0] mem [DEPTH];

  logic mem_we;
  logic [PTR_W-1:0] mem_addr;
  logic [NUM_CH*TW-1:0] mem_wdata;
  logic [NUM_CH*TW-1:0] row;
  logic [TW-1:0] trace0;
  logic cond_true;
  logic ms_tick;
  logic sample;
  logic trig_ev;
  logic done_ev;
  logic rearm_wr;
  logic toggle_wr;
  logic data_rd;
  logic [PTR_W:0] phys_sum;
  logic [PTR_W-1:0] phys_idx;
  logic [DATA_W-1:0] rd_mux;

  assign trace0 = i_trace[TW-1:0];

  // condition evaluation; against the programmed value
  // OR tests any common set bit, so 18h fires on bit 3 or bit 4
  always_comb begin
    unique case (q.cond)
      COND_EQ: cond_true = (trace0 == q.tval);
      COND_NE: cond_true = (trace0 != q.tval);
      COND_GT: cond_true = (trace0 > q.tval);
      COND_LT: cond_true = (trace0 < q.tval);
      COND_OR: cond_true = ((trace0 & q.tval) != '0);
      COND_NOR: cond_true = ((trace0 & q.tval) == '0);
      COND_AND: cond_true = ((trace0 & q.tval) == q.tval);
      COND_NAND: cond_true = ((trace0 & q.tval) != q.tval);
    endcase
  end

  always_comb begin
    row = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      if (q.en[c]) begin
        row[c*TW +: TW] = i_trace[c*TW +: TW];
      end
    end
  end

  assign ms_tick = (q.ms_cnt == MS_LAST);
  // interval in ms ticks; zero acts as one
  assign sample = ms_tick && ((q.st == TTC_ARMED) || (q.st == TTC_POST)) &&
                  ((q.rate == '0) || (q.iv_cnt >= q.rate - 15'd1));

  assign rearm_wr = i_wr && (i_addr == OFS_CTRL) && i_wdata[CTRL_REARM_BIT];
  assign toggle_wr = i_wr && (i_addr == OFS_CTRL) && i_wdata[CTRL_TOGGLE_BIT];
  assign data_rd = i_rd && (i_addr == OFS_RD_DATA);

  // read-out index 0 is the oldest row, which is the next one to be overwritten
  assign phys_sum = {1'b0, q.wr_ptr} + {1'b0, q.sel_idx};
  assign phys_idx = (phys_sum >= (PTR_W + 1)'(DEPTH)) ?
                    PTR_W'(phys_sum - (PTR_W + 1)'(DEPTH)) : phys_sum[PTR_W-1:0];

  always_comb begin
    rd_mux = '0;
    unique case (i_addr)
      OFS_CTRL: begin
        rd_mux[CTRL_MODE_BIT] = q.mode;
        rd_mux[CTRL_EN_LSB +: NUM_CH] = q.en;
      end
      OFS_COND: rd_mux[2:0] = q.cond;
      OFS_TVAL: rd_mux[TW-1:0] = q.tval;
      OFS_RATE: rd_mux[14:0] = q.rate;
      OFS_POST: rd_mux[6:0] = q.post;
      OFS_STATUS: begin
        rd_mux[STAT_RUN_BIT] = (q.st == TTC_ARMED);
        rd_mux[STAT_STOP_BIT] = (q.st != TTC_ARMED);
        rd_mux[STAT_POST_BIT] = (q.st == TTC_POST);
        rd_mux[STAT_CLEAR_BIT] = (q.st == TTC_CLEAR);
        rd_mux[STAT_PTR_LSB +: PTR_W] = q.wr_ptr;
      end
      OFS_IRQ_STAT: rd_mux[1:0] = q.irq_st;
      OFS_IRQ_MASK: rd_mux[1:0] = q.irq_mask;
      OFS_RD_SEL: begin
        rd_mux[PTR_W-1:0] = q.sel_idx;
        rd_mux[SEL_CH_LSB +: 3] = q.sel_ch;
      end
      OFS_RD_DATA: rd_mux[TW-1:0] = mem[phys_idx][q.sel_ch*TW +: TW];
      default: rd_mux = '0;
    endcase
  end

  always_comb begin
    d = q;
    mem_we = 1'b0;
    mem_addr = q.wr_ptr;
    mem_wdata = row;
    trig_ev = 1'b0;
    done_ev = 1'b0;

    if ((q.st == TTC_ARMED) || (q.st == TTC_POST)) begin
      d.ms_cnt = ms_tick ? '0 : q.ms_cnt + MSW'(1);
      if (sample) begin
        d.iv_cnt = '0;
      end else if (ms_tick) begin
        d.iv_cnt = q.iv_cnt + 15'd1;
      end
    end

    unique case (q.st)
      TTC_CLEAR: begin
        // sweep every row to zero before arming
        mem_we = 1'b1;
        mem_wdata = '0;
        d.wr_ptr = q.wr_ptr + PTR_W'(1);
        if (q.wr_ptr == PTR_LAST) begin
          d.wr_ptr = '0;
          d.st = TTC_ARMED;
          d.ms_cnt = '0;
          d.iv_cnt = '0;
        end
      end
      TTC_ARMED: begin
        if (sample) begin
          mem_we = 1'b1;
          d.wr_ptr = (q.wr_ptr == PTR_LAST) ? '0 : q.wr_ptr + PTR_W'(1);
          if (cond_true) begin
            trig_ev = 1'b1;
            // post count is the percentage of a 100-row buffer
            if (q.post == '0) begin
              done_ev = 1'b1;
            end else begin
              d.post_left = q.post;
              d.st = TTC_POST;
            end
          end
        end
      end
      TTC_POST: begin
        if (sample) begin
          mem_we = 1'b1;
          d.wr_ptr = (q.wr_ptr == PTR_LAST) ? '0 : q.wr_ptr + PTR_W'(1);
          d.post_left = q.post_left - 7'd1;
          if (q.post_left == 7'd1) begin
            done_ev = 1'b1;
          end
        end
      end
      TTC_STOP: begin
      end
    endcase

    if (done_ev) begin
      // continuous keeps collecting unless a read-out asked to stop
      // single shot stops after one capture
      if (q.mode && !q.stop_req) begin
        d.st = TTC_ARMED;
      end else begin
        d.st = TTC_STOP;
        d.stop_req = 1'b0;
      end
    end

    // viewing captured data ends continuous collection after this capture
    if (data_rd && q.mode && (q.st != TTC_STOP)) begin
      d.stop_req = 1'b1;
    end

    if (i_wr) begin
      unique case (i_addr)
        OFS_CTRL: d.en = i_wdata[CTRL_EN_LSB +: NUM_CH];
        OFS_COND: d.cond = i_wdata[2:0];
        OFS_TVAL: d.tval = i_wdata[TW-1:0];
        // out-of-range settings saturate rather than wrap
        OFS_RATE: d.rate = (i_wdata[31:15] != '0 || i_wdata[14:0] > RATE_MAX_MS) ?
                           RATE_MAX_MS : i_wdata[14:0];
        OFS_POST: d.post = (i_wdata[31:7] != '0 || i_wdata[6:0] > POST_MAX_PCT) ?
                           POST_MAX_PCT : i_wdata[6:0];
        OFS_IRQ_MASK: d.irq_mask = i_wdata[1:0];
        OFS_RD_SEL: begin
          d.sel_idx = (i_wdata[PTR_W-1:0] > PTR_LAST) ? PTR_LAST : i_wdata[PTR_W-1:0];
          d.sel_ch = i_wdata[SEL_CH_LSB +: 3];
        end
        default: begin
        end
      endcase
    end

    // each toggle write flips the mode
    if (toggle_wr) begin
      d.mode = ~q.mode;
    end

    // re-arm from any state returns to Running after the clear sweep
    if (rearm_wr) begin
      d.st = TTC_CLEAR;
      d.wr_ptr = '0;
      d.stop_req = 1'b0;
      d.post_left = '0;
    end

    // set wins over a write-one-to-clear in the same cycle
    d.irq_st = q.irq_st;
    if (i_wr && (i_addr == OFS_IRQ_STAT)) begin
      d.irq_st = q.irq_st & ~i_wdata[1:0];
    end
    if (trig_ev) begin
      d.irq_st[IRQ_TRIG_BIT] = 1'b1;
    end
    if (done_ev) begin
      d.irq_st[IRQ_DONE_BIT] = 1'b1;
    end

    d.rdata = i_rd ? rd_mux : '0;
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      q <= '{st: TTC_CLEAR, mode: RST_MODE, en: RST_EN, cond: RST_COND, tval: RST_TVAL,
             rate: RST_RATE, post: RST_POST, default: '0};
    end else begin
      q <= d;
    end
  end

  // buffer has no reset: the clear sweep that follows reset zeroes it
  always_ff @(posedge i_mclk) begin
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
  end

  assign o_rdata = q.rdata;
  assign o_running = (q.st == TTC_ARMED);
  assign o_irq = |(q.irq_st & q.irq_mask);

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_rearm;
    rearm_wr;
  endsequence

  sequence s_clearing;
    (q.st == TTC_CLEAR) [*8];
  endsequence

  sequence s_sweep_end;
    (q.st == TTC_CLEAR) && (q.wr_ptr == PTR_LAST) && !rearm_wr;
  endsequence

  AST_TRIG_ARMED: assert property (
    trig_ev |-> (q.st == TTC_ARMED) && cond_true && sample)
    else $error("trigger outside armed state or without condition");

  AST_TRIG_CH0: assert property (
    (sample && q.st == TTC_ARMED && q.cond == COND_EQ && trace0 != q.tval) |-> !trig_ev)
    else $error("trigger fired while trace 0 did not match");

  AST_REARM_CLEARS: assert property (
    s_rearm ##1 (q.wr_ptr == '0) |-> s_clearing)
    else $error("re-arm did not start the clear sweep");

  AST_SWEEP_RUNS: assert property (
    s_sweep_end |=> (q.st == TTC_ARMED) && o_running && (q.wr_ptr == '0))
    else $error("clear sweep did not return to running");

  AST_POST_LOAD: assert property (
    (trig_ev && q.post != '0 && !rearm_wr) |=>
      (q.st == TTC_POST) && (q.post_left == $past(q.post)))
    else $error("post count not loaded at trigger");

  AST_SINGLE_STOP: assert property (
    (done_ev && !q.mode && !rearm_wr) |=>
      (q.st == TTC_STOP) ##1 ($past(rearm_wr) || q.st == TTC_STOP))
    else $error("single shot did not stop after capture");

  AST_CONT_REARM: assert property (
    (done_ev && q.mode && !q.stop_req && !rearm_wr) |=> (q.st == TTC_ARMED))
    else $error("continuous mode did not re-arm");

  AST_STOP_HOLD: assert property (
    (q.st == TTC_STOP && !rearm_wr) |=> (q.st == TTC_STOP) && $stable(q.wr_ptr))
    else $error("stopped buffer moved without re-arm");

  AST_SAMPLE_MS: assert property (
    (ms_tick && (q.st == TTC_ARMED || q.st == TTC_POST) && q.rate == '0) |-> sample)
    else $error("zero interval did not sample on the millisecond");

  AST_PTR_WRAP: assert property (
    (mem_we && q.wr_ptr == PTR_LAST && !rearm_wr && q.st != TTC_CLEAR) |=> (q.wr_ptr == '0))
    else $error("write pointer did not wrap at 100 rows");

  AST_MODE_TOGGLE: assert property (
    toggle_wr |=> (q.mode != $past(q.mode)))
    else $error("mode did not toggle");

endmodule // ttc_recorder

/* File: tb/ttc_terminal.sv */
/*
  Operator terminal model: drives the recorder register port with single-cycle
  strobes and picks up read data in the cycle after the read strobe.
  Assumes it shares the recorder clock and that the recorder never stalls.
*/
module ttc_terminal
  import ttc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic [ttc_pkg::DATA_W-1:0] i_rdata,
  output logic [ttc_pkg::ADDR_W-1:0] o_addr,
  output logic [ttc_pkg::DATA_W-1:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_addr = '0;
    o_wdata = '0;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_mclk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_mclk);
    o_wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge i_mclk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_mclk);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask

  task automatic rearm();
    logic [DATA_W-1:0] d;
    rd(OFS_RD_DATA, d);
    wr(OFS_CTRL, 32'h0000fb04);
  endtask
endmodule // ttc_terminal

/* File: tb/test_trend_trigger_capture.sv */
/*
  Self-checking bench for the trend recorder: register reset values, post-trigger
  count and spacing, freeze, read-out, interrupts, all trigger conditions, continuous mode.
  Assumes a shortened millisecond count so that captures take a few hundred cycles.
*/
module test_trend_trigger_capture;
  import ttc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CMS = 4;
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [NUM_CH*TRACE_W-1:0] trace = '0;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] d;
  logic [DATA_W-1:0] p;
  logic wr;
  logic rd;
  logic running;
  logic irq;
  int errors = 0;
  int samples_checked = 0;
  int n;
  // per condition: code, trigger value, a false operand, a true operand
  logic [2:0] cc [8] = '{COND_EQ, COND_NE, COND_GT, COND_LT, COND_OR, COND_NOR, COND_AND,
    COND_NAND};
  logic [15:0] cv [8] = '{16'h5, 16'h5, 16'h5, 16'h5, 16'h8, 16'h8, 16'h18, 16'h18};
  logic [15:0] cf [8] = '{16'h4, 16'h5, 16'h5, 16'h5, 16'h10, 16'h8, 16'h10, 16'h18};
  logic [15:0] ct [8] = '{16'h5, 16'h4, 16'h6, 16'h4, 16'h18, 16'h10, 16'h18, 16'h10};

  always #5 i_mclk = ~i_mclk;

  ttc_recorder #(.TW(TRACE_W), .CYC_MS(CMS)) ttc_recorder_i (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_trace(trace), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_running(running), .o_irq(irq)
  );

  ttc_terminal ttc_terminal_i (
    .i_mclk(i_mclk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd)
  );

  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, m, s, e);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic set0(input logic [15:0] v);
    @(posedge i_mclk);
    trace[15:0] <= v;
  endtask

  // bounded wait for the running flag
  task automatic wait_run(input logic v);
    int k;
    k = 0;
    #1;
    while (running !== v && k < 300) begin
      @(posedge i_mclk);
      #1;
      k++;
    end
  endtask

  initial begin
    #(20000 * 10);
    errors++;
    end_of_test();
  end

  initial begin
    for (int c = 1; c < NUM_CH; c++) trace[c*TRACE_W +: TRACE_W] = 16'h0100 + 16'(c);
    repeat (8) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    ttc_terminal_i.rd(OFS_CTRL, d);
    chk(d, 32'h0000ff00, "ctrl reset");
    ttc_terminal_i.rd(OFS_COND, d);
    chk(d, 32'h4, "cond reset");
    ttc_terminal_i.rd(OFS_TVAL, d);
    chk(d, 32'h18, "tval reset");
    ttc_terminal_i.rd(OFS_POST, d);
    chk(d, 32'h14, "post reset");
    ttc_terminal_i.rd(8'h30, d);
    chk(d, 32'h0, "unmapped read");
    wait_run(1'b1);
    chk(32'(running), 32'h1, "armed after reset");
    $display("test reset done");

    ttc_terminal_i.wr(OFS_CTRL, 32'h0000fb00);
    ttc_terminal_i.wr(OFS_POST, 32'h3);
    ttc_terminal_i.wr(OFS_RATE, 32'h2);
    ttc_terminal_i.wr(OFS_TVAL, 32'h8);
    ttc_terminal_i.wr(OFS_IRQ_MASK, 32'h2);
    set0(16'h0010);
    repeat (40) @(posedge i_mclk);
    #1;
    chk(32'(running), 32'h1, "alarm ignored for fault value");
    set0(16'h0008);
    wait_run(1'b0);
    n = 0;
    while (irq !== 1'b1 && n < 100) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    chk(n, 3 * 2 * CMS, "post samples time");
    ttc_terminal_i.rd(OFS_STATUS, p);
    chk(p[1:0], 2'b10, "stopped after capture");
    repeat (40) @(posedge i_mclk);
    ttc_terminal_i.rd(OFS_STATUS, d);
    chk(d, p, "buffer frozen");
    ttc_terminal_i.wr(OFS_RD_SEL, 32'h00000163);
    ttc_terminal_i.rd(OFS_RD_DATA, d);
    chk(d, 32'h0101, "newest row channel 1");
    ttc_terminal_i.wr(OFS_RD_SEL, 32'h00000263);
    ttc_terminal_i.rd(OFS_RD_DATA, d);
    chk(d, 32'h0, "inactive channel");
    ttc_terminal_i.wr(OFS_IRQ_STAT, 32'h2);
    #1;
    chk(32'(irq), 32'h0, "irq cleared");
    ttc_terminal_i.rd(OFS_IRQ_STAT, d);
    chk(d, 32'h1, "trigger event left");
    ttc_terminal_i.rearm();
    ttc_terminal_i.rd(OFS_STATUS, d);
    chk(d & 32'h7f0b, 32'h010a, "clearing sweep under way");
    wait_run(1'b1);
    chk(32'(running), 32'h1, "re-arm restores running");
    $display("test post capture done");

    ttc_terminal_i.wr(OFS_POST, 32'h0);
    ttc_terminal_i.wr(OFS_RATE, 32'h0);
    ttc_terminal_i.wr(OFS_IRQ_MASK, 32'h0);
    for (int i = 0; i < 8; i++) begin
      ttc_terminal_i.wr(OFS_COND, 32'(cc[i]));
      ttc_terminal_i.wr(OFS_TVAL, 32'(cv[i]));
      set0(cf[i]);
      ttc_terminal_i.wr(OFS_IRQ_STAT, 32'h3);
      ttc_terminal_i.rearm();
      wait_run(1'b1);
      repeat (20) @(posedge i_mclk);
      #1;
      chk(32'(running), 32'h1, "false condition holds off");
      set0(ct[i]);
      wait_run(1'b0);
      ttc_terminal_i.rd(OFS_IRQ_STAT, d);
      chk(d, 32'h3, "trigger and done");
    end
    $display("test conditions done");

    ttc_terminal_i.wr(OFS_POST, 32'h2);
    ttc_terminal_i.rearm();
    ttc_terminal_i.wr(OFS_CTRL, 32'h0000fb02);
    ttc_terminal_i.rd(OFS_CTRL, d);
    chk(d, 32'h0000fb01, "continuous selected");
    wait_run(1'b1);
    wait_run(1'b0);
    wait_run(1'b1);
    chk(32'(running), 32'h1, "auto re-arm");
    ttc_terminal_i.rd(OFS_RD_DATA, d);
    repeat (30) @(posedge i_mclk);
    ttc_terminal_i.rd(OFS_STATUS, d);
    chk(d[1:0], 2'b10, "read-out stops capture");
    ttc_terminal_i.wr(OFS_CTRL, 32'h0000fb02);
    ttc_terminal_i.rd(OFS_CTRL, d);
    chk(d, 32'h0000fb00, "single selected");
    $display("test continuous done");
    end_of_test();
  end
endmodule // test_trend_trigger_capture
